// ===== tcir_pkg.sv
// Constants for the trace capability identification register bank.
// Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
package tcir_pkg;

    // Register byte offsets
    localparam logic [7:0] TCIR_OFF_CAP_ONE = 8'h00;
    localparam logic [7:0] TCIR_OFF_CAP_TWO = 8'h04;
    localparam logic [7:0] TCIR_OFF_CTRL = 8'h08;
    localparam logic [7:0] TCIR_OFF_STATUS = 8'h0C;
    localparam int TCIR_ADDR_W = 8;

    // Field positions in capability_word_one (lowest bit of each field)
    localparam int TCIR_F1_SERIAL_OUT_LSB = 22;
    localparam int TCIR_F1_PERIODIC_ALIGN_LSB = 20;
    localparam int TCIR_F1_HW_EVENT_LSB = 18;
    localparam int TCIR_F1_STAMP_DIV_LSB = 16;
    localparam int TCIR_F1_TRIGGER_MODE_LSB = 14;
    localparam int TCIR_F1_OUTPUT_BUS_LSB = 10;
    localparam int TCIR_F1_ALIGN_PERIOD_LSB = 8;
    localparam int TCIR_F1_FORCED_STAMP_BIT = 7;
    localparam int TCIR_F1_STAMP_RATE_BIT = 6;
    localparam int TCIR_F1_STAMP_KIND_LSB = 4;
    localparam int TCIR_F1_WIRE_FORMAT_LSB = 0;

    // Field positions in capability_word_two
    localparam int TCIR_F2_PORT_CLASS_LSB = 16;
    localparam int TCIR_F2_NATIVE_WIDTH_LSB = 12;
    localparam int TCIR_F2_TRANSFER_CLASS_LSB = 9;
    localparam int TCIR_F2_ACCESS_FILTER_LSB = 7;
    localparam int TCIR_F2_PORT_FORCING_BIT = 6;

    // Common two-bit support encodings
    localparam logic [1:0] TCIR_SUP_PROBE = 2'h0;
    localparam logic [1:0] TCIR_SUP_ABSENT = 2'h1;
    localparam logic [1:0] TCIR_SUP_PRESENT = 2'h2;
    localparam logic [1:0] TCIR_SUP_WRITABLE = 2'h3;

    // Field-specific encodings
    localparam logic [1:0] TCIR_TRIG_NONE = 2'h0;
    localparam logic [1:0] TCIR_TRIG_MULTI = 2'h1;
    localparam logic [1:0] TCIR_TRIG_BOTH = 2'h2;
    localparam logic [3:0] TCIR_BUS_PLAIN = 4'h0;
    localparam logic [3:0] TCIR_BUS_TRIGGER = 4'h1;
    localparam logic [1:0] TCIR_STAMP_DIFF = 2'h0;
    localparam logic [1:0] TCIR_STAMP_ABS = 2'h1;
    localparam logic [1:0] TCIR_STAMP_NONE = 2'h2;
    localparam logic [3:0] TCIR_WIRE_FORMAT_V2 = 4'h1;
    localparam logic [1:0] TCIR_CLASS_BASIC = 2'h0;
    localparam logic [1:0] TCIR_CLASS_EXTENDED = 2'h1;
    localparam logic [1:0] TCIR_CLASS_BOTH = 2'h2;
    localparam logic [3:0] TCIR_WIDTH_32 = 4'h0;
    localparam logic [3:0] TCIR_WIDTH_64 = 4'h1;
    localparam logic [1:0] TCIR_XFER_INVARIANT = 2'h0;
    localparam logic [1:0] TCIR_XFER_GUARANTEED = 2'h1;
    localparam logic [1:0] TCIR_XFER_BOTH = 2'h2;

    // Read-count control and status
    localparam int TCIR_CTRL_COUNT_EN_BIT = 0;
    localparam int TCIR_CTRL_COUNT_CLR_BIT = 1;
    localparam int TCIR_COUNT_W = 16;
    localparam logic TCIR_RST_COUNT_EN = 1'b0;
    localparam logic [TCIR_COUNT_W-1:0] TCIR_RST_COUNT = 16'h0000;
    localparam logic [TCIR_COUNT_W-1:0] TCIR_COUNT_MAX = 16'hFFFF;
    localparam logic [31:0] TCIR_RST_RDATA = 32'h0000_0000;

    // AHB-Lite codes
    localparam logic [1:0] TCIR_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] TCIR_HSIZE_WORD = 3'h2;
    localparam logic TCIR_HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        TCIR_PH_IDLE = 2'b00,
        TCIR_PH_WDATA = 2'b01
    } tcir_phase_type;

    typedef enum logic [2:0] {
        TCIR_SEL_NONE = 3'h0,
        TCIR_SEL_CAP_ONE = 3'h1,
        TCIR_SEL_CAP_TWO = 3'h2,
        TCIR_SEL_CTRL = 3'h3,
        TCIR_SEL_STATUS = 3'h4
    } tcir_sel_type;

endpackage

// ===== tcir_cap_words.sv
// Builds the two constant capability words from build parameters.
// Assumes parameters are fixed at elaboration; undefined codes are replaced.
`timescale 1ns/100ps
`default_nettype none
module tcir_cap_words
    import tcir_pkg::*;
#(
    parameter logic [1:0] SERIAL_OUT = TCIR_SUP_ABSENT,
    parameter logic [1:0] PERIODIC_ALIGN = TCIR_SUP_WRITABLE,
    parameter logic [1:0] HW_EVENT = TCIR_SUP_PRESENT,
    parameter logic [1:0] STAMP_DIV = TCIR_SUP_PRESENT,
    parameter logic [1:0] TRIGGER_MODE = TCIR_TRIG_BOTH,
    parameter logic [3:0] OUTPUT_BUS = TCIR_BUS_TRIGGER,
    parameter logic [1:0] ALIGN_PERIOD = TCIR_SUP_WRITABLE,
    parameter logic FORCED_STAMP = 1'b1,
    parameter logic STAMP_RATE_WR = 1'b1,
    parameter logic [1:0] STAMP_KIND = TCIR_STAMP_ABS,
    parameter logic [1:0] PORT_CLASS = TCIR_CLASS_BOTH,
    parameter logic [3:0] NATIVE_WIDTH = TCIR_WIDTH_64,
    parameter logic [1:0] TRANSFER_CLASS = TCIR_XFER_BOTH,
    parameter logic [1:0] ACCESS_FILTER = TCIR_SUP_PRESENT,
    parameter logic PORT_FORCING = 1'b1
) (
    output logic [31:0] word_one, // Capability word one
    output logic [31:0] word_two  // Capability word two
);

    // Three-value fields: 0b11 is reserved, fall back to the neutral code
    function automatic logic [1:0] three_way(input logic [1:0] v, input logic [1:0] fallback);
        three_way = (v == 2'h3) ? fallback : v;
    endfunction

    // Four-bit fields with only two defined codes
    function automatic logic [3:0] two_code(input logic [3:0] v, input logic [3:0] fallback);
        two_code = (v > 4'h1) ? fallback : v;
    endfunction

    always_comb begin
        word_one = 32'h0000_0000;
        word_one[TCIR_F1_SERIAL_OUT_LSB +: 2] = three_way(SERIAL_OUT, TCIR_SUP_PROBE);
        word_one[TCIR_F1_PERIODIC_ALIGN_LSB +: 2] = PERIODIC_ALIGN;
        word_one[TCIR_F1_HW_EVENT_LSB +: 2] = three_way(HW_EVENT, TCIR_SUP_PROBE);
        word_one[TCIR_F1_STAMP_DIV_LSB +: 2] = three_way(STAMP_DIV, TCIR_SUP_PROBE);
        word_one[TCIR_F1_TRIGGER_MODE_LSB +: 2] = three_way(TRIGGER_MODE, TCIR_TRIG_NONE);
        word_one[TCIR_F1_OUTPUT_BUS_LSB +: 4] = two_code(OUTPUT_BUS, TCIR_BUS_PLAIN);
        word_one[TCIR_F1_ALIGN_PERIOD_LSB +: 2] = ALIGN_PERIOD;
        word_one[TCIR_F1_FORCED_STAMP_BIT] = FORCED_STAMP;
        word_one[TCIR_F1_STAMP_RATE_BIT] = STAMP_RATE_WR;
        // No-timestamp is the safe fallback for a reserved code
        word_one[TCIR_F1_STAMP_KIND_LSB +: 2] = three_way(STAMP_KIND, TCIR_STAMP_NONE);
        word_one[TCIR_F1_WIRE_FORMAT_LSB +: 4] = TCIR_WIRE_FORMAT_V2;

        word_two = 32'h0000_0000;
        word_two[TCIR_F2_PORT_CLASS_LSB +: 2] = three_way(PORT_CLASS, TCIR_CLASS_BASIC);
        word_two[TCIR_F2_NATIVE_WIDTH_LSB +: 4] = two_code(NATIVE_WIDTH, TCIR_WIDTH_32);
        word_two[TCIR_F2_TRANSFER_CLASS_LSB +: 2] = three_way(TRANSFER_CLASS, TCIR_XFER_INVARIANT);
        word_two[TCIR_F2_ACCESS_FILTER_LSB +: 2] = three_way(ACCESS_FILTER, TCIR_SUP_PROBE);
        word_two[TCIR_F2_PORT_FORCING_BIT] = PORT_FORCING;
    end

endmodule
`default_nettype wire

// ===== tcir_regs.sv
// AHB-Lite slave holding the trace capability identification registers.
// Assumes a single master, word transfers, synchronous inputs on hclk.
//
// Functional notes
// - Word one bits 19:18 report hardware event enable: probe, absent or present.
// - Bits 17:16 report stamp divider support; bits 5:4 report stamp kind.
// - Bits 15:14 report trigger modes: none indicated, multi-shot only, or both.
// - Bits 13:10 report plain output bus or output bus with trigger support.
// - Bits 9:8 report alignment period register: probe, absent, no-mode, with-mode.
// - Bit 7 flags forced stamp bit; bit 6 flags writable stamp rate register.
// - Bits 3:0 read 0b0001; reserved field encodings are never returned.
// - Word two always exists; its bits 31:18 and 11 read zero.
// - Word two bits 17:16 give port classes, bits 15:12 native width.
// - Word two bits 10:9 report supported port transfer kinds.
// - Word two bits 8:7 report access level filter register support.
// - Word two bit 6 set only when both forcing registers exist.
// - Word one bits 21:20 report periodic alignment enable support, four codes.
// - Word one bits 23:22 report serial output enable; bits 31:24 read zero.
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tcir_regs
    import tcir_pkg::*;
#(
    parameter logic [1:0] SERIAL_OUT = TCIR_SUP_ABSENT,
    parameter logic [1:0] PERIODIC_ALIGN = TCIR_SUP_WRITABLE,
    parameter logic [1:0] HW_EVENT = TCIR_SUP_PRESENT,
    parameter logic [1:0] STAMP_DIV = TCIR_SUP_PRESENT,
    parameter logic [1:0] TRIGGER_MODE = TCIR_TRIG_BOTH,
    parameter logic [3:0] OUTPUT_BUS = TCIR_BUS_TRIGGER,
    parameter logic [1:0] ALIGN_PERIOD = TCIR_SUP_WRITABLE,
    parameter logic FORCED_STAMP = 1'b1,
    parameter logic STAMP_RATE_WR = 1'b1,
    parameter logic [1:0] STAMP_KIND = TCIR_STAMP_ABS,
    parameter logic [1:0] PORT_CLASS = TCIR_CLASS_BOTH,
    parameter logic [3:0] NATIVE_WIDTH = TCIR_WIDTH_64,
    parameter logic [1:0] TRANSFER_CLASS = TCIR_XFER_BOTH,
    parameter logic [1:0] ACCESS_FILTER = TCIR_SUP_PRESENT,
    parameter logic PORT_FORCING = 1'b1
) (
    input wire logic hclk,                           // Bus clock, 200 MHz
    input wire logic hresetn,                        // Async reset, active low
    input wire logic hsel,                           // Slave select
    input wire logic [tcir_pkg::TCIR_ADDR_W-1:0] haddr, // Byte address
    input wire logic [1:0] htrans,                   // Transfer type
    input wire logic hwrite,                         // Write when high
    input wire logic [2:0] hsize,                    // Transfer size
    input wire logic [31:0] hwdata,                  // Write data
    input wire logic hready,                         // Bus ready in
    output logic [31:0] hrdata,                      // Read data
    output logic hreadyout,                          // Slave ready
    output logic hresp                               // Response, always OKAY
);
    import tcir_pkg::*;

    typedef struct packed {
        tcir_phase_type phase;
        tcir_sel_type wr_sel;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic count_en;
        logic [TCIR_COUNT_W-1:0] read_count;
    } tcir_state_type;

    localparam tcir_state_type TCIR_STATE_RST = '{
        phase: TCIR_PH_IDLE,
        wr_sel: TCIR_SEL_NONE,
        rdata: TCIR_RST_RDATA,
        ready: 1'b1,
        resp: TCIR_HRESP_OKAY,
        count_en: TCIR_RST_COUNT_EN,
        read_count: TCIR_RST_COUNT
    };

    tcir_state_type s_r;
    tcir_state_type s_nxt;
    logic [31:0] cap_one;
    logic [31:0] cap_two;
    logic accept;
    tcir_sel_type addr_sel;

    tcir_cap_words #(
        .SERIAL_OUT(SERIAL_OUT),
        .PERIODIC_ALIGN(PERIODIC_ALIGN),
        .HW_EVENT(HW_EVENT),
        .STAMP_DIV(STAMP_DIV),
        .TRIGGER_MODE(TRIGGER_MODE),
        .OUTPUT_BUS(OUTPUT_BUS),
        .ALIGN_PERIOD(ALIGN_PERIOD),
        .FORCED_STAMP(FORCED_STAMP),
        .STAMP_RATE_WR(STAMP_RATE_WR),
        .STAMP_KIND(STAMP_KIND),
        .PORT_CLASS(PORT_CLASS),
        .NATIVE_WIDTH(NATIVE_WIDTH),
        .TRANSFER_CLASS(TRANSFER_CLASS),
        .ACCESS_FILTER(ACCESS_FILTER),
        .PORT_FORCING(PORT_FORCING)
    ) u_cap_words (
        .word_one(cap_one),
        .word_two(cap_two)
    );

    // Address decode, shared by the read and the write path
    function automatic tcir_sel_type decode(input logic [TCIR_ADDR_W-1:0] a);
        case (a)
            TCIR_OFF_CAP_ONE: decode = TCIR_SEL_CAP_ONE;
            TCIR_OFF_CAP_TWO: decode = TCIR_SEL_CAP_TWO;
            TCIR_OFF_CTRL: decode = TCIR_SEL_CTRL;
            TCIR_OFF_STATUS: decode = TCIR_SEL_STATUS;
            default: decode = TCIR_SEL_NONE;
        endcase
    endfunction

    function automatic logic is_capability(input tcir_sel_type sel);
        is_capability = (sel == TCIR_SEL_CAP_ONE) || (sel == TCIR_SEL_CAP_TWO);
    endfunction

    // Unmapped addresses read as zero with an OKAY response
    function automatic logic [31:0] read_mux(input tcir_sel_type sel, input logic [31:0] one,
                                             input logic [31:0] two, input logic en,
                                             input logic [TCIR_COUNT_W-1:0] cnt);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (sel)
            TCIR_SEL_CAP_ONE: v = one;
            TCIR_SEL_CAP_TWO: v = two;
            TCIR_SEL_CTRL: v[TCIR_CTRL_COUNT_EN_BIT] = en;
            TCIR_SEL_STATUS: v[TCIR_COUNT_W-1:0] = cnt;
            default: v = 32'h0000_0000;
        endcase
        read_mux = v;
    endfunction

    assign addr_sel = decode(haddr);
    // Only word-sized NONSEQ transfers are served; others are ignored
    assign accept = hsel && hready && (htrans == TCIR_HTRANS_NONSEQ) && (hsize == TCIR_HSIZE_WORD);

    always_comb begin
        s_nxt = s_r;
        // Zero wait states: the slave never stretches a transfer
        s_nxt.ready = 1'b1;
        s_nxt.resp = TCIR_HRESP_OKAY;

        // Data phase of an earlier write
        if (s_r.phase == TCIR_PH_WDATA) begin
            case (s_r.wr_sel)
                TCIR_SEL_CTRL: begin
                    s_nxt.count_en = hwdata[TCIR_CTRL_COUNT_EN_BIT];
                    if (hwdata[TCIR_CTRL_COUNT_CLR_BIT]) begin
                        s_nxt.read_count = TCIR_RST_COUNT;
                    end
                end
                // Capability words and status hold no state a write could touch
                TCIR_SEL_CAP_ONE, TCIR_SEL_CAP_TWO: s_nxt.read_count = s_nxt.read_count;
                default: s_nxt.read_count = s_nxt.read_count;
            endcase
            s_nxt.phase = TCIR_PH_IDLE;
            s_nxt.wr_sel = TCIR_SEL_NONE;
        end

        if (accept) begin
            if (hwrite) begin
                s_nxt.phase = TCIR_PH_WDATA;
                s_nxt.wr_sel = addr_sel;
            end else begin
                s_nxt.rdata = read_mux(addr_sel, cap_one, cap_two, s_r.count_en, s_r.read_count);
                // Increment after the clear so a same-cycle read is not lost
                if (s_r.count_en && is_capability(addr_sel) && (s_nxt.read_count != TCIR_COUNT_MAX)) begin
                    s_nxt.read_count = s_nxt.read_count + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= TCIR_STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata = s_r.rdata;
    assign hreadyout = s_r.ready;
    assign hresp = s_r.resp;

endmodule
`default_nettype wire

// ===== tcir_regs_assertions.sv
// Concurrent checks on the capability register bank, bound to every tcir_regs.
// Assumes one hclk domain and a zero-wait-state slave.
`timescale 1ns/100ps
`default_nettype none
module tcir_regs_checker
    import tcir_pkg::*;
(
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [tcir_pkg::TCIR_ADDR_W-1:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic hready, // Bus ready in
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Slave ready
    input wire logic hresp // Response
);
    logic take;
    logic rd1_r, rd2_r, ok1_r, ok2_r;
    logic [31:0] last1_r, last2_r;
    assign take = hsel && hready && htrans == TCIR_HTRANS_NONSEQ && hsize == TCIR_HSIZE_WORD;
    // Data-phase flags: hrdata carries a capability word at the next edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd1_r <= 1'b0;
            rd2_r <= 1'b0;
            ok1_r <= 1'b0;
            ok2_r <= 1'b0;
            last1_r <= 32'h0000_0000;
            last2_r <= 32'h0000_0000;
        end else begin
            rd1_r <= take && !hwrite && haddr == TCIR_OFF_CAP_ONE;
            rd2_r <= take && !hwrite && haddr == TCIR_OFF_CAP_TWO;
            if (rd1_r) begin
                last1_r <= hrdata;
                ok1_r <= 1'b1;
            end
            if (rd2_r) begin
                last2_r <= hrdata;
                ok2_r <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_READY_OKAY: assert property (hreadyout == 1'b1 && hresp == TCIR_HRESP_OKAY)
        else $error("slave stalled or answered an error");
    AST_W1_FORMAT: assert property (rd1_r |-> hrdata[3:0] == TCIR_WIRE_FORMAT_V2)
        else $error("wire format code wrong");
    AST_W1_TOP_ZERO: assert property (rd1_r |-> hrdata[31:24] == 8'h00)
        else $error("word one top byte not zero");
    AST_W1_NO_RESERVED: assert property (rd1_r |-> hrdata[23:22] != 2'h3 && hrdata[19:18] != 2'h3
        && hrdata[17:16] != 2'h3 && hrdata[15:14] != 2'h3 && hrdata[13:10] <= 4'h1 && hrdata[5:4] != 2'h3)
        else $error("word one returned a reserved code");
    AST_W2_ZEROS: assert property (rd2_r |-> hrdata[31:18] == 14'h0000 && hrdata[11] == 1'b0)
        else $error("word two reserved bits set");
    AST_W2_NO_RESERVED: assert property (rd2_r |-> hrdata[17:16] != 2'h3 && hrdata[15:12] <= 4'h1
        && hrdata[10:9] != 2'h3 && hrdata[8:7] != 2'h3)
        else $error("word two returned a reserved code");
    AST_W1_CONSTANT: assert property (rd1_r && ok1_r |-> hrdata == last1_r)
        else $error("word one changed between reads");
    AST_W2_CONSTANT: assert property (rd2_r && ok2_r |-> hrdata == last2_r)
        else $error("word two changed between reads");
    AST_WRITE_NO_EFFECT: assert property (take && hwrite |=> $stable(hrdata))
        else $error("read data moved after a write");
endmodule
bind tcir_regs tcir_regs_checker u_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));
`default_nettype wire

// ===== trace_capability_id_regs_tb_top.sv
// Self-checking bench for the capability register bank over AHB-Lite.
// Assumes tcir_pkg, the design and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module trace_capability_id_regs_tb_top;
    import tcir_pkg::*;
    localparam logic [31:0] W1 = 32'h007A_87D1;
    localparam logic [31:0] W2 = 32'h0002_1540;
    localparam logic [31:0] W1_ALT = 32'h0091_4221;
    localparam logic [31:0] W2_ALT = 32'h0001_0280;
    // Alternate build: the other codes, plus reserved values that must fall back
    localparam logic [1:0] ALT_SERIAL_OUT = TCIR_SUP_PRESENT;
    localparam logic [1:0] ALT_PERIODIC_ALIGN = TCIR_SUP_ABSENT;
    localparam logic [1:0] ALT_HW_EVENT = 2'h3;
    localparam logic [1:0] ALT_STAMP_DIV = TCIR_SUP_ABSENT;
    localparam logic [1:0] ALT_TRIGGER_MODE = TCIR_TRIG_MULTI;
    localparam logic [3:0] ALT_OUTPUT_BUS = 4'h5;
    localparam logic [1:0] ALT_ALIGN_PERIOD = TCIR_SUP_PRESENT;
    localparam logic ALT_FORCED_STAMP = 1'b0;
    localparam logic ALT_STAMP_RATE_WR = 1'b0;
    localparam logic [1:0] ALT_STAMP_KIND = 2'h3;
    localparam logic [1:0] ALT_PORT_CLASS = TCIR_CLASS_EXTENDED;
    localparam logic [3:0] ALT_NATIVE_WIDTH = TCIR_WIDTH_32;
    localparam logic [1:0] ALT_TRANSFER_CLASS = TCIR_XFER_GUARANTEED;
    localparam logic [1:0] ALT_ACCESS_FILTER = TCIR_SUP_ABSENT;
    localparam logic ALT_PORT_FORCING = 1'b0;
    logic hclk, hresetn, hsel, hwrite, hready, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, hrdata_alt, rd, rd_alt;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    tcir_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp));
    // Second build covers the other codes and the hardware event, output bus and stamp kind fallbacks
    tcir_regs #(.SERIAL_OUT(ALT_SERIAL_OUT), .PERIODIC_ALIGN(ALT_PERIODIC_ALIGN), .HW_EVENT(ALT_HW_EVENT),
        .STAMP_DIV(ALT_STAMP_DIV), .TRIGGER_MODE(ALT_TRIGGER_MODE), .OUTPUT_BUS(ALT_OUTPUT_BUS),
        .ALIGN_PERIOD(ALT_ALIGN_PERIOD), .FORCED_STAMP(ALT_FORCED_STAMP), .STAMP_RATE_WR(ALT_STAMP_RATE_WR),
        .STAMP_KIND(ALT_STAMP_KIND), .PORT_CLASS(ALT_PORT_CLASS), .NATIVE_WIDTH(ALT_NATIVE_WIDTH),
        .TRANSFER_CLASS(ALT_TRANSFER_CLASS), .ACCESS_FILTER(ALT_ACCESS_FILTER), .PORT_FORCING(ALT_PORT_FORCING))
    dut_alt (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata_alt), .hreadyout(), .hresp());
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Single transfer; read data of both builds taken at the data-phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= TCIR_HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        rd_alt = hrdata_alt;
    endtask
    task automatic t_reset_state();
        chk("hrdata", 32'h0000_0000, hrdata);
        chk("hreadyout", 32'h0000_0001, {31'h0, hready});
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
        $display("test reset_state done");
    endtask
    task automatic t_words();
        bus(1'b0, TCIR_OFF_CAP_ONE, 32'h0);
        chk("word one", W1, rd);
        chk("word one alt", W1_ALT, rd_alt);
        bus(1'b0, TCIR_OFF_CAP_TWO, 32'h0);
        chk("word two", W2, rd);
        chk("word two alt", W2_ALT, rd_alt);
        $display("test words done");
    endtask
    task automatic t_writes_ignored();
        bus(1'b1, TCIR_OFF_CTRL, 32'h0000_0003);
        bus(1'b1, TCIR_OFF_CAP_ONE, 32'hFFFF_FFFF);
        bus(1'b1, TCIR_OFF_CAP_TWO, 32'hFFFF_FFFF);
        bus(1'b0, TCIR_OFF_STATUS, 32'h0);
        chk("count after writes", 32'h0000_0000, rd);
        bus(1'b0, TCIR_OFF_CAP_ONE, 32'h0);
        chk("word one after write", W1, rd);
        bus(1'b0, TCIR_OFF_CAP_TWO, 32'h0);
        chk("word two after write", W2_ALT, rd_alt);
        bus(1'b0, TCIR_OFF_STATUS, 32'h0);
        chk("count after reads", 32'h0000_0002, rd);
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0000_0000, rd);
        // Byte-sized read must be ignored: read data and count stay put
        hsize <= 3'h0;
        bus(1'b0, TCIR_OFF_CAP_ONE, 32'h0);
        hsize <= TCIR_HSIZE_WORD;
        chk("byte read ignored", 32'h0000_0000, rd);
        bus(1'b0, TCIR_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h0000_0001, rd);
        bus(1'b0, TCIR_OFF_STATUS, 32'h0);
        chk("count after byte read", 32'h0000_0002, rd);
        // Clear with a non-zero count, so the clear bit is really exercised
        bus(1'b1, TCIR_OFF_CTRL, 32'h0000_0003);
        bus(1'b0, TCIR_OFF_STATUS, 32'h0);
        chk("count after clear", 32'h0000_0000, rd);
        $display("test writes_ignored done");
    endtask
    task automatic t_second_reset();
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("hrdata in reset", 32'h0000_0000, hrdata);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, TCIR_OFF_CTRL, 32'h0);
        chk("ctrl after reset", 32'h0000_0000, rd);
        bus(1'b0, TCIR_OFF_CAP_ONE, 32'h0);
        chk("word one after reset", W1, rd);
        $display("test second_reset done");
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = TCIR_HSIZE_WORD;
        hwdata = 32'h0000_0000;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_state();
        t_words();
        t_writes_ignored();
        t_second_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
